// [design/cfg_loader_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Byte-wide configuration registers at their printed offsets.
// Notes:   Included by its bare name.
`ifndef CFG_LOADER_CONSTS_SVH
`define CFG_LOADER_CONSTS_SVH
`define OFF_CAP_HEAD        8'h34
`define OFF_POWER_LINK      8'h41
`define OFF_POWER_CSR       8'h44
`define OFF_HS_ID           8'h48
`define OFF_HS_LINK         8'h49
`define OFF_HOTSWAP_CONTROL_STATUS          8'h4a
`define OFF_PD_ID           8'h4c
`define OFF_PD_LINK         8'h4d
`define OFF_HOST_STATUS     8'h06
`define OFF_CTRL3           8'h6f
`define OFF_LOCAL_MISC_CONTROL           8'h8c
`define RST_CAP_HEAD        8'h40
`define RST_POWER_LINK      8'h48
`define RST_HS_ID           8'h06
`define RST_HS_LINK         8'h4c
`define RST_PD_ID           8'h03
`define RST_PD_LINK         8'h00
`define RST_HOST_STATUS     8'h10
`define BIT_CAP_PRESENT     4
`define BIT_HS_ENUM         7
`define BIT_CTRL_RELOAD     5
`define BIT_CTRL_SWRST      6
`define BIT_LOCAL_MISC_CONTROL_DONE      2
`define PSTATE_D0           2'b00
`define PSTATE_D3HOT        2'b11
`define LOAD_BYTES          8'd88
`define EE_READ_OP          3'b110
`define RESET_PULSE_NS      1000
`define MCLK_MHZ            50
`define RESET_PULSE_CYC     ((`RESET_PULSE_NS * `MCLK_MHZ + 999) / 1000)
`endif

// [design/cfg_loader_pkg.sv]
// Purpose: Types shared by the loader and its serial engine.
// Assumes: Nothing beyond the constants header.
// Notes:   Types only.
package cfg_loader_pkg;
	typedef enum logic [3:0] {
		LD_IDLE = 4'b0001,
		LD_REQ  = 4'b0010,
		LD_WAIT = 4'b0100,
		LD_DONE = 4'b1000
	} load_state_t;
	typedef enum logic [3:0] {
		SR_IDLE = 4'b0001,
		SR_CMD  = 4'b0010,
		SR_DATA = 4'b0100,
		SR_END  = 4'b1000
	} ser_state_t;
endpackage : cfg_loader_pkg

// [design/ee_req_if.sv]
// Purpose: Byte request channel between the loader and the serial engine.
// Assumes: Toggle handshake across the two clock domains.
// Notes:   req_tgl lives on mclk, ack_tgl on the link clock.
`timescale 1ns/1ps
interface ee_req_if;
	logic       req_tgl;
	logic [7:0] addr;
	logic       ack_tgl;
	logic [7:0] data;
	logic       sel;
	modport loader (output req_tgl, output addr, output sel,
		input ack_tgl, input data);
	modport engine (input req_tgl, input addr, input sel,
		output ack_tgl, output data);
endinterface : ee_req_if

// [design/ee_serial_engine.sv]
// Purpose: Reads one EEPROM byte per request on the link clock.
// Assumes: Three-wire part, read opcode then 8 address bits, MSB first.
// Notes:   Request toggle is synchronised with three flops.
`timescale 1ns/1ps
`include "cfg_loader_consts.svh"
module ee_serial_engine (
	// Link clock and reset
	input  wire logic eeclk_i,
	input  wire logic nrst_i,
	// Loader side
	ee_req_if.engine  rq,
	// Pins
	output logic      ee_cs_o,
	output logic      ee_do_o,
	output logic      ee_oe_o,
	input  wire logic ee_di_i
);
	logic [2:0]  sync_q, sync_d;
	logic        seen_q, seen_d;
	logic        ack_q, ack_d;
	logic [7:0]  data_q, data_d;
	logic [10:0] sh_q, sh_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        cs_q, cs_d, do_q, do_d;
	logic        oe_q, oe_d;
	logic [2:0]  di_q, di_d;
	cfg_loader_pkg::ser_state_t st_q, st_d;
	logic        go;
	assign go = (sync_q[1] == sync_q[2]) && (sync_q[2] != seen_q);
	assign rq.ack_tgl = ack_q;
	assign rq.data = data_q;
	assign ee_cs_o = cs_q;
	assign ee_do_o = do_q;
	// The line is driven only while opcode and address bits are shifted.
	assign ee_oe_o = oe_q;
	always_comb begin
		sync_d = {sync_q[1:0], rq.req_tgl};
		di_d = {di_q[1:0], ee_di_i};
		seen_d = seen_q;
		ack_d = ack_q;
		data_d = data_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		cs_d = rq.sel; // [R11]
		do_d = do_q;
		oe_d = (st_q == cfg_loader_pkg::SR_CMD);
		st_d = st_q;
		case (st_q)
			cfg_loader_pkg::SR_IDLE: begin
				if (go) begin
					seen_d = sync_q[2];
					sh_d = {`EE_READ_OP, rq.addr}; // [R10]
					cnt_d = 4'ha;
					st_d = cfg_loader_pkg::SR_CMD;
				end
			end
			cfg_loader_pkg::SR_CMD: begin
				do_d = sh_q[10];
				sh_d = {sh_q[9:0], 1'b0};
				if (cnt_q == 4'h0) begin
					// Five extra cycles cover the part's turnaround
					// and the three input flops.
					cnt_d = 4'hc;
					st_d = cfg_loader_pkg::SR_DATA;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			cfg_loader_pkg::SR_DATA: begin
				do_d = 1'b0;
				if (cnt_q <= 4'h7) begin
					data_d = {data_q[6:0], di_q[2]};
				end
				if (cnt_q == 4'h0) begin
					st_d = cfg_loader_pkg::SR_END;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			cfg_loader_pkg::SR_END: begin
				ack_d = ~ack_q;
				st_d = cfg_loader_pkg::SR_IDLE;
			end
			default: st_d = cfg_loader_pkg::SR_IDLE;
		endcase
	end
	always_ff @(posedge eeclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_q <= 3'h0;
			di_q <= 3'h0;
			seen_q <= 1'b0;
			ack_q <= 1'b0;
			data_q <= 8'h00;
			sh_q <= 11'h000;
			cnt_q <= 4'h0;
			cs_q <= 1'b0;
			do_q <= 1'b0;
			oe_q <= 1'b0;
			st_q <= cfg_loader_pkg::SR_IDLE;
		end else begin
			sync_q <= sync_d;
			di_q <= di_d;
			seen_q <= seen_d;
			ack_q <= ack_d;
			data_q <= data_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			cs_q <= cs_d;
			do_q <= do_d;
			oe_q <= oe_d;
			st_q <= st_d;
		end
	end
endmodule : ee_serial_engine

// [design/cfg_loader.sv]
// Purpose: Configuration loader and capability list registers.
// Assumes: Local byte bus on mclk_i; EEPROM engine on eeclk_i.
// Notes:   Product data ID reads back as zero locally.
// Functional notes
// R1: Power link resets to 48h.
// R2: Hot-swap link resets to 4Ch.
// R3: Product data link resets to zero.
// R4: Programmer writes only default or zero.
// R5: Links local-only; hot-swap link also EEPROM.
// R6: Hot-swap ID writable local and EEPROM.
// R7: Product data ID write-only locally.
// R8: Early silicon writes preserve enumeration bit; here a write replaces the whole byte.
// R9: Power-up load reads 88 bytes from zero.
// R10: Serial three-wire 2k/4k EEPROM supported.
// R11: Chip select held during load.
// R12: Control bits give direct EEPROM access.
// R13: Host uses product data registers only.
// R14: Local processor sets init-done bit.
// R15: Low data line sets init-done itself.
// R16: Reload on reload bit rising edge.
// R17: Reload on D3hot to D0.
// R18: D3hot to D0 pulses local reset.
// R19: Software reset bit pulses local reset.
// R20: Capability head resets to 40h.
// R21: Head and present bit local-only.
// R22: Bytes loaded in order; done after all.
`timescale 1ns/1ps
`include "cfg_loader_consts.svh"
module cfg_loader #(
	parameter int RST_CYC = `RESET_PULSE_CYC
) (
	// Clocks and reset
	input  wire logic       mclk_i,
	input  wire logic       eeclk_i,
	input  wire logic       nrst_i,
	// Local register bus
	input  wire logic       lwr_i,
	input  wire logic       lrd_i,
	input  wire logic [7:0] laddr_i,
	input  wire logic [7:0] lwdata_i,
	output logic      [7:0] lrdata_o,
	// Host power-state write
	input  wire logic       pwr_wr_i,
	input  wire logic [1:0] pwr_state_i,
	// EEPROM pins
	output logic            eeprom_chip_select_o,
	output logic            eeprom_serial_data_o,
	output logic            eeprom_serial_data_oe_o,
	input  wire logic       eeprom_serial_data_i,
	output logic            eeprom_clk_o,
	// Status
	output logic            init_done_o,
	output logic            local_reset_output_n_o
);
	ee_req_if rq ();
	logic       ee_cs, ee_do, ee_oe;
	ee_serial_engine u_eng (
		.eeclk_i (eeclk_i),
		.nrst_i  (nrst_i),
		.rq      (rq),
		.ee_cs_o (ee_cs),
		.ee_do_o (ee_do),
		.ee_oe_o (ee_oe),
		.ee_di_i (eeprom_serial_data_i)
	);
	////////////////////////////////////////////////////////////////////
	// Crossing of the acknowledge toggle, three flops.
	logic [2:0] ack_s_q, ack_s_d;
	logic       ack_seen_q, ack_seen_d;
	logic       ack_ev;
	logic [2:0] di_s_q, di_s_d;
	assign ack_ev = (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] != ack_seen_q);
	////////////////////////////////////////////////////////////////////
	// Registers.
	logic [7:0] cap_head_q, cap_head_d, pw_link_q, pw_link_d;
	logic [7:0] hs_id_q, hs_id_d, hs_link_q, hs_link_d;
	logic [7:0] pd_id_q, pd_id_d, pd_link_q, pd_link_d;
	logic [7:0] hotswap_control_status_q, hotswap_control_status_d, hstat_q, hstat_d, ctrl_q, ctrl_d;
	logic [1:0] pstate_q, pstate_d;
	logic       done_q, done_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] addr_q, addr_d;
	logic       req_q, req_d, sel_q, sel_d;
	logic [15:0] rcnt_q, rcnt_d;
	logic       rstn_q, rstn_d;
	logic       direct;
	cfg_loader_pkg::load_state_t st_q, st_d;
	assign rq.req_tgl = req_q;
	assign rq.addr = addr_q;
	assign rq.sel = sel_q;
	// Direct access uses the low control bits; bit 0 enables it, bit 1 selects the part.
	assign direct = ctrl_q[0];
	// The EEPROM clock mirrors the link clock; only sampled while selected.
	assign eeprom_clk_o = eeclk_i;
	assign eeprom_chip_select_o = direct ? ctrl_q[1] : ee_cs; // [R12]
	assign eeprom_serial_data_o = direct ? ctrl_q[2] : ee_do;
	assign eeprom_serial_data_oe_o = direct | ee_oe;
	assign lrdata_o = rdata_q;
	assign init_done_o = done_q;
	assign local_reset_output_n_o = rstn_q;
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = lwr_i && (a == o);
	endfunction : hit
	always_comb begin
		ack_s_d = {ack_s_q[1:0], rq.ack_tgl};
		di_s_d = {di_s_q[1:0], eeprom_serial_data_i};
		ack_seen_d = ack_seen_q;
		cap_head_d = cap_head_q;
		pw_link_d = pw_link_q;
		hs_id_d = hs_id_q;
		hs_link_d = hs_link_q;
		pd_id_d = pd_id_q;
		pd_link_d = pd_link_q;
		hotswap_control_status_d = hotswap_control_status_q;
		hstat_d = hstat_q;
		ctrl_d = ctrl_q;
		pstate_d = pstate_q;
		done_d = done_q;
		addr_d = addr_q;
		req_d = req_q;
		sel_d = sel_q;
		st_d = st_q;
		rcnt_d = (rcnt_q != 16'h0) ? rcnt_q - 16'h1 : 16'h0;
		rstn_d = (rcnt_q == 16'h0);
		if (hit(laddr_i, `OFF_CAP_HEAD)) cap_head_d = lwdata_i; // [R21]
		if (hit(laddr_i, `OFF_HOST_STATUS))
			hstat_d[`BIT_CAP_PRESENT] = lwdata_i[`BIT_CAP_PRESENT]; // [R21]
		if (hit(laddr_i, `OFF_POWER_LINK)) pw_link_d = lwdata_i; // [R5]
		if (hit(laddr_i, `OFF_PD_LINK)) pd_link_d = lwdata_i; // [R5]
		if (hit(laddr_i, `OFF_HS_ID)) hs_id_d = lwdata_i; // [R6]
		if (hit(laddr_i, `OFF_HS_LINK)) hs_link_d = lwdata_i; // [R5]
		if (hit(laddr_i, `OFF_PD_ID)) pd_id_d = lwdata_i; // [R7]
		if (hit(laddr_i, `OFF_HOTSWAP_CONTROL_STATUS)) hotswap_control_status_d = lwdata_i; // [R8]
		if (hit(laddr_i, `OFF_LOCAL_MISC_CONTROL) && lwdata_i[`BIT_LOCAL_MISC_CONTROL_DONE])
			done_d = 1'b1; // [R14]
		if (hit(laddr_i, `OFF_CTRL3)) begin
			ctrl_d = lwdata_i;
			if (lwdata_i[`BIT_CTRL_SWRST] && !ctrl_q[`BIT_CTRL_SWRST])
				rcnt_d = RST_CYC[15:0]; // [R19]
		end
		if (pwr_wr_i) begin
			pstate_d = pwr_state_i;
			if (pstate_q == `PSTATE_D3HOT && pwr_state_i == `PSTATE_D0)
				rcnt_d = RST_CYC[15:0]; // [R18]
		end
		if (ack_ev) ack_seen_d = ack_s_q[2];
		case (st_q)
			cfg_loader_pkg::LD_IDLE: begin
				if ((hit(laddr_i, `OFF_CTRL3) &&
				     lwdata_i[`BIT_CTRL_RELOAD] &&
				     !ctrl_q[`BIT_CTRL_RELOAD]) || // [R16]
				    (pwr_wr_i && pstate_q == `PSTATE_D3HOT &&
				     pwr_state_i == `PSTATE_D0)) begin // [R17]
					done_d = 1'b0;
					addr_d = 8'h00;
					st_d = cfg_loader_pkg::LD_REQ;
				end
			end
			cfg_loader_pkg::LD_REQ: begin
				sel_d = 1'b1; // [R11]
				req_d = ~req_q;
				st_d = cfg_loader_pkg::LD_WAIT;
			end
			cfg_loader_pkg::LD_WAIT: begin
				if (ack_ev) begin
					// A low data line on the first byte means no EEPROM.
					if (addr_q == 8'h00 && rq.data == 8'h00 &&
					    di_s_q[2] == 1'b0 && di_s_q[1] == 1'b0) begin
						st_d = cfg_loader_pkg::LD_DONE; // [R15]
					end else begin
						case (addr_q)
							`OFF_HS_ID: hs_id_d = rq.data; // [R6]
							`OFF_HS_LINK: hs_link_d = rq.data; // [R5]
							default: ;
						endcase
						if (addr_q == `LOAD_BYTES - 8'd1) begin
							st_d = cfg_loader_pkg::LD_DONE; // [R9]
						end else begin
							addr_d = addr_q + 8'd1; // [R22]
							st_d = cfg_loader_pkg::LD_REQ;
						end
					end
				end
			end
			cfg_loader_pkg::LD_DONE: begin
				sel_d = 1'b0;
				done_d = 1'b1; // [R22]
				st_d = cfg_loader_pkg::LD_IDLE;
			end
			default: st_d = cfg_loader_pkg::LD_IDLE;
		endcase
		rdata_d = rdata_q;
		if (lrd_i) begin
			case (laddr_i)
				`OFF_CAP_HEAD: rdata_d = cap_head_q;
				`OFF_HOST_STATUS: rdata_d = hstat_q;
				`OFF_POWER_LINK: rdata_d = pw_link_q;
				`OFF_POWER_CSR: rdata_d = {6'h00, pstate_q};
				`OFF_HS_ID: rdata_d = hs_id_q;
				`OFF_HS_LINK: rdata_d = hs_link_q;
				`OFF_HOTSWAP_CONTROL_STATUS: rdata_d = hotswap_control_status_q;
				`OFF_PD_ID: rdata_d = 8'h00; // [R7]
				`OFF_PD_LINK: rdata_d = pd_link_q;
				`OFF_CTRL3: rdata_d = ctrl_q;
				`OFF_LOCAL_MISC_CONTROL: rdata_d = {5'h00, done_q, 2'h0};
				default: rdata_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_s_q <= 3'h0;
			di_s_q <= 3'h7;
			ack_seen_q <= 1'b0;
			cap_head_q <= `RST_CAP_HEAD; // [R20]
			pw_link_q <= `RST_POWER_LINK; // [R1]
			hs_id_q <= `RST_HS_ID;
			hs_link_q <= `RST_HS_LINK; // [R2]
			pd_id_q <= `RST_PD_ID;
			pd_link_q <= `RST_PD_LINK; // [R3]
			hotswap_control_status_q <= 8'h00;
			hstat_q <= `RST_HOST_STATUS;
			ctrl_q <= 8'h00;
			pstate_q <= `PSTATE_D0;
			done_q <= 1'b0;
			rdata_q <= 8'h00;
			addr_q <= 8'h00;
			req_q <= 1'b0;
			sel_q <= 1'b0;
			rcnt_q <= 16'h0;
			rstn_q <= 1'b0;
			st_q <= cfg_loader_pkg::LD_REQ; // [R9]
		end else begin
			ack_s_q <= ack_s_d;
			di_s_q <= di_s_d;
			ack_seen_q <= ack_seen_d;
			cap_head_q <= cap_head_d;
			pw_link_q <= pw_link_d;
			hs_id_q <= hs_id_d;
			hs_link_q <= hs_link_d;
			pd_id_q <= pd_id_d;
			pd_link_q <= pd_link_d;
			hotswap_control_status_q <= hotswap_control_status_d;
			hstat_q <= hstat_d;
			ctrl_q <= ctrl_d;
			pstate_q <= pstate_d;
			done_q <= done_d;
			rdata_q <= rdata_d;
			addr_q <= addr_d;
			req_q <= req_d;
			sel_q <= sel_d;
			rcnt_q <= rcnt_d;
			rstn_q <= rstn_d;
			st_q <= st_d;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Checks.
	AST_DONE_AFTER_LOAD: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		st_q == cfg_loader_pkg::LD_DONE |=> done_q) // [R22]
		else $error("init done not set after load");
	AST_NO_DONE_DURING_LOAD: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		st_q == cfg_loader_pkg::LD_WAIT && $past(st_q) ==
		cfg_loader_pkg::LD_REQ |-> !done_q) // [R22]
		else $error("init done during load");
	AST_SEL_IN_LOAD: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		st_q == cfg_loader_pkg::LD_WAIT |-> sel_q) // [R11]
		else $error("chip select dropped during load");
	AST_SWRST_PULSE: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		hit(laddr_i, `OFF_CTRL3) && lwdata_i[`BIT_CTRL_SWRST] &&
		!ctrl_q[`BIT_CTRL_SWRST] |=> ##1 !rstn_q) // [R19]
		else $error("software reset did not pulse local reset");
	AST_D3_RESET: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		pwr_wr_i && pstate_q == `PSTATE_D3HOT &&
		pwr_state_i == `PSTATE_D0 |=> ##1 !rstn_q) // [R18]
		else $error("D3hot to D0 did not pulse local reset");
	AST_RELOAD: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		st_q == cfg_loader_pkg::LD_IDLE && hit(laddr_i, `OFF_CTRL3) &&
		lwdata_i[`BIT_CTRL_RELOAD] && !ctrl_q[`BIT_CTRL_RELOAD]
		|=> st_q == cfg_loader_pkg::LD_REQ && addr_q == 8'h00) // [R16]
		else $error("reload not started");
	AST_PD_ID_HIDDEN: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		lrd_i && laddr_i == `OFF_PD_ID |=> rdata_q == 8'h00) // [R7]
		else $error("product data id readable");
	AST_LINK_LOCAL: assert property (@(posedge mclk_i)
		disable iff (!nrst_i)
		hit(laddr_i, `OFF_POWER_LINK) |=> pw_link_q == $past(lwdata_i))
		// [R5]
		else $error("power link write lost");
endmodule : cfg_loader

// [dv/ee_model.sv]
// Purpose: Behavioural three-wire serial EEPROM on the device's pins.
// Assumes: Read opcode and 8 address bits shifted in while the device
//          drives; 8 data bits come back MSB first.
// Notes:   Counts bytes per chip-select frame for the bench.
`timescale 1ns/1ps
module ee_model (
	// Pins
	input  wire logic       clk_i,
	input  wire logic       cs_i,
	input  wire logic       di_i,
	input  wire logic       oe_i,
	input  wire logic       absent_i,
	output logic            do_o,
	output logic            drv_o,
	// Bench view
	output int              bytes_o,
	output logic      [7:0] last_addr_o,
	output logic            op_bad_o
);
	logic [10:0] sh;
	int          nin;
	int          nout;

	// Offset 49h holds zero, the only legal value other than the default.
	function automatic logic [7:0] mem(input logic [7:0] a);
		return (a == 8'h49) ? 8'h00 : (a ^ 8'h5a);
	endfunction : mem

	initial begin
		do_o = 1'b0;
		drv_o = 1'b0;
		bytes_o = 0;
		last_addr_o = 8'h00;
		op_bad_o = 1'b0;
		nin = 0;
		nout = 0;
	end

	always @(posedge cs_i) begin
		bytes_o = 0;
	end

	always @(posedge clk_i) begin
		if (!cs_i || absent_i) begin
			nin = 0;
			nout = 0;
			#1 drv_o = 1'b0;
		end else if (oe_i) begin
			sh = {sh[9:0], di_i};
			nin++;
			if (nin == 11) begin
				nin = 0;
				nout = 8;
				if (sh[10:8] !== 3'b110)
					op_bad_o = 1'b1;
				last_addr_o = sh[7:0];
				bytes_o++;
			end
		end else if (nout > 0) begin
			#1 drv_o = 1'b1;
			do_o = mem(last_addr_o)[nout-1];
			nout--;
		end else begin
			// A released line goes to the pull-up level.
			#1 drv_o = 1'b0;
		end
	end
endmodule : ee_model

// [dv/test_config_load_and_capability_chain.sv]
// Purpose: Self-checking bench for the configuration loader.
// Assumes: Local byte bus driven on falling edges of mclk_i.
// Notes:   Reset pulse shortened to 4 cycles.
`timescale 1ns/1ps
module test_config_load_and_capability_chain;
	logic       mclk_i = 1'b0;
	logic       eeclk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       lwr_i = 1'b0;
	logic       lrd_i = 1'b0;
	logic [7:0] laddr_i = 8'h00;
	logic [7:0] lwdata_i = 8'h00;
	logic       pwr_wr_i = 1'b0;
	logic [1:0] pwr_state_i = 2'b00;
	logic       absent = 1'b1;
	logic [7:0] rdat;
	logic [7:0] m_last;
	logic [7:0] lrdata;
	logic       cs, ddo, doe, done, lrst_n, m_do, m_drv, op_bad;
	wire logic  ddi;
	int         m_bytes;
	int         n;
	int         error_cnt = 0;
	int         comparisons = 0;

	always #10 mclk_i = ~mclk_i;
	always #6 eeclk_i = ~eeclk_i;

	// With no EEPROM fitted the line is pulled low instead of high.
	assign ddi = doe ? ddo : (m_drv ? m_do : ~absent);

	cfg_loader #(.RST_CYC(4)) u_dut (
		.mclk_i(mclk_i), .eeclk_i(eeclk_i), .nrst_i(nrst_i),
		.lwr_i(lwr_i), .lrd_i(lrd_i), .laddr_i(laddr_i),
		.lwdata_i(lwdata_i), .lrdata_o(lrdata),
		.pwr_wr_i(pwr_wr_i), .pwr_state_i(pwr_state_i),
		.eeprom_chip_select_o(cs), .eeprom_serial_data_o(ddo),
		.eeprom_serial_data_oe_o(doe), .eeprom_serial_data_i(ddi),
		.eeprom_clk_o(), .init_done_o(done),
		.local_reset_output_n_o(lrst_n));

	ee_model u_ee (
		.clk_i(eeclk_i), .cs_i(cs), .di_i(ddo), .oe_i(doe),
		.absent_i(absent), .do_o(m_do), .drv_o(m_drv),
		.bytes_o(m_bytes), .last_addr_o(m_last), .op_bad_o(op_bad));

	////////////////////////////////////////////////////////////////////////
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: byte got %h exp %h", $time, g, e);
		end
	endtask : cmp8

	task automatic cmp1(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: flag got %b exp %b", $time, g, e);
		end
	endtask : cmp1

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		laddr_i = a;
		lwdata_i = d;
		lwr_i = 1'b1;
		@(negedge mclk_i);
		lwr_i = 1'b0;
	endtask : wr

	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk_i);
		laddr_i = a;
		lrd_i = 1'b1;
		@(negedge mclk_i);
		lrd_i = 1'b0;
		cmp8(lrdata, e);
	endtask : chk

	task automatic pw(input logic [1:0] s);
		@(negedge mclk_i);
		pwr_state_i = s;
		pwr_wr_i = 1'b1;
		@(negedge mclk_i);
		pwr_wr_i = 1'b0;
	endtask : pw

	function automatic logic pick(input int w);
		return (w == 0) ? cs : ((w == 1) ? done : lrst_n);
	endfunction : pick

	task automatic wait_lvl(input int w, input logic v, input int lim);
		for (int i = 0; i < lim && pick(w) !== v; i++)
			@(negedge mclk_i);
		cmp1(pick(w), v);
	endtask : wait_lvl

	task automatic do_reset;
		@(negedge mclk_i);
		nrst_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		nrst_i = 1'b1;
	endtask : do_reset

	task automatic end_of_test;
		$display("Errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		#600000;
		error_cnt++;
		$display("Error %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		do_reset();
		wait_lvl(1, 1'b1, 20000);
		chk(8'h34, 8'h40);
		chk(8'h41, 8'h48);
		chk(8'h49, 8'h4c);
		chk(8'h4d, 8'h00);
		chk(8'h48, 8'h06);
		chk(8'h4c, 8'h00);
		chk(8'h06, 8'h10);
		chk(8'hf0, 8'h00);
		wr(8'h4c, 8'h00);
		chk(8'h4c, 8'h00);
		wr(8'h49, 8'h00);
		chk(8'h49, 8'h00);
		wr(8'h49, 8'h4c);
		wr(8'h34, 8'h00);
		chk(8'h34, 8'h00);
		wr(8'h34, 8'h40);
		wr(8'h4a, 8'h80);
		wr(8'h48, 8'h00);
		chk(8'h48, 8'h00);
		chk(8'h4a, 8'h80);
		wr(8'h6f, 8'h03);
		cmp1(cs, 1'b1);
		wr(8'h6f, 8'h00);
		cmp1(cs, 1'b0);
		wr(8'h8c, 8'h04);
		cmp1(done, 1'b1);
		absent = 1'b1 ^ 1'b1;
		// Software reset first; the local reset pulse must last 4 cycles.
		wr(8'h6f, 8'h40);
		n = 0;
		for (int i = 0; i < 20 && (n == 0 || lrst_n === 1'b0); i++) begin
			@(negedge mclk_i);
			if (lrst_n === 1'b0)
				n++;
		end
		cmp8(n[7:0], 8'd4);
		wr(8'h6f, 8'h00);
		wr(8'h6f, 8'h20);
		wait_lvl(0, 1'b1, 200);
		wait_lvl(0, 1'b0, 40000);
		cmp8(m_bytes[7:0], 8'd88);
		cmp8(m_last, 8'h57);
		cmp1(op_bad, 1'b0);
		chk(8'h48, 8'h12);
		chk(8'h49, 8'h00);
		chk(8'h41, 8'h48);
		chk(8'h4d, 8'h00);
		wr(8'h6f, 8'h00);
		wr(8'h49, 8'h4c);
		pw(2'b11);
		pw(2'b00);
		wait_lvl(2, 1'b0, 10);
		wait_lvl(0, 1'b1, 200);
		wait_lvl(0, 1'b0, 40000);
		chk(8'h49, 8'h00);
		do_reset();
		wait_lvl(0, 1'b1, 200);
		cmp1(done, 1'b0);
		wait_lvl(0, 1'b0, 40000);
		wait_lvl(1, 1'b1, 100);
		cmp8(m_bytes[7:0], 8'd88);
		end_of_test();
	end
endmodule : test_config_load_and_capability_chain
